// ### logic/mpt_timer.sv
// Multipurpose pulse timer with APB register access.
//
// Design decisions made here: the APB register port and the placing of the registers.
`default_nettype none
// Every delay is measured in ticks of a fixed sampling period that a divider
// derives from pclk, so the interval register holds ticks rather than seconds.
// One run counter serves all four modes. Only one mode is active at a time,
// so sharing it costs nothing and keeps elapsed and remaining consistent.
// Pins reach the core through two-flop synchronisers, which adds two cycles of
// latency to every trigger, hold and clear event. Software can drive the same
// three controls through the control register for bring-up.
// Limitation: the interval is an unsigned tick count, so the longest delay is
// bounded by the 32-bit counter, far beyond any practical setting.
module mpt_timer
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger_in,
   input wire logic hold_in,
   input wire logic priority_clear,
   output logic timer_out,
   output logic [31:0] elapsed_time,
   output logic [31:0] remaining_time
);
   mpt_pkg::mpt_req_s req;
   logic [2:0] mode_r;
   logic sw_hold_r;
   logic sw_clear_r;
   logic sw_trig_r;
   logic [31:0] interval_length_r;
   logic [1:0] trig_sync_r;
   logic [1:0] hold_sync_r;
   logic [1:0] clr_sync_r;
   logic [mpt_pkg::DIV_W-1:0] div_r;
   logic tick;
   logic [31:0] elapsed_r;
   logic running_r;
   logic trig_now;
   logic trig_prev;
   logic chg_restart;
   logic hold_now;
   logic clear_now;
   logic done;
   logic access;

   // Remaining time never wraps below zero, even if software shrinks the
   // interval under a run that has already counted past it.
   function automatic logic [31:0] sat_sub(input logic [31:0] a, input logic [31:0] b);
      sat_sub = (a > b) ? a - b : 32'h0000_0000;
   endfunction : sat_sub

   // The request travels as one struct so the write and read decoders see
   // exactly the same address and direction.
   assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
   assign access = psel && penable;

   // Pins from outside the clock domain: the second stage is all that logic reads.
   // Edge detection uses a register of the combined trigger, not a third stage,
   // so a software trigger is seen as one edge and not as an edge every cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trig_sync_r <= 2'h0;
         hold_sync_r <= 2'h0;
         clr_sync_r <= 2'h0;
      end
      else
      begin
         trig_sync_r <= {trig_sync_r[0], trigger_in};
         hold_sync_r <= {hold_sync_r[0], hold_in};
         clr_sync_r <= {clr_sync_r[0], priority_clear};
      end
   end

   // The software trigger bit is ORed in so the block can be exercised without pins.
   assign trig_now = trig_sync_r[1] | sw_trig_r;
   assign hold_now = hold_sync_r[1] | sw_hold_r;
   assign clear_now = clr_sync_r[1] | sw_clear_r;
   // In change-delay mode any movement of the input starts the stability count
   // afresh, and the tick phase has to start afresh with it.
   assign chg_restart = (mode_r == mpt_pkg::MODE_CHANGE) && (trig_now != trig_prev);

   // Sampling-period divider; ticks are the only time base for delays.
   // It rests at zero between runs and restarts when a change-delay input moves,
   // so every run counts whole ticks and a pulse lasts exactly the interval.
   // A free-running divider would be simpler, but the first tick of a run would
   // then arrive anywhere from one cycle to a full period after the start.
   // While held it keeps its phase, so a pause loses no part of a tick.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_r <= '0;
      else if (!running_r || chg_restart)
         div_r <= '0;
      else if (hold_now)
         div_r <= div_r;
      else if (div_r == mpt_pkg::DIV_LAST)
         div_r <= '0;
      else
         div_r <= div_r + 1'b1;
   end
   assign tick = (div_r == mpt_pkg::DIV_LAST);

   // Register writes land only at the access edge where pready is high.
   // The control bits are levels: a software clear stays in force until it is
   // written back to zero, like the pin.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_r <= mpt_pkg::MODE_RESET;
         sw_hold_r <= 1'b0;
         sw_clear_r <= 1'b0;
         sw_trig_r <= 1'b0;
         interval_length_r <= mpt_pkg::INTERVAL_DEF_TICKS;
      end
      else if (access && req.write && pready)
      begin
         unique case (req.addr)
            mpt_pkg::ADDR_CTRL:
            begin
               // Illegal mode codes are refused so the timer always has a defined behaviour.
               if (req.wdata[mpt_pkg::CTRL_MODE_LSB +: 3] >= mpt_pkg::MODE_PULSE &&
                   req.wdata[mpt_pkg::CTRL_MODE_LSB +: 3] <= mpt_pkg::MODE_CHANGE)
                  mode_r <= req.wdata[mpt_pkg::CTRL_MODE_LSB +: 3];
               sw_hold_r <= req.wdata[mpt_pkg::CTRL_HOLD_BIT];
               sw_clear_r <= req.wdata[mpt_pkg::CTRL_CLEAR_BIT];
               sw_trig_r <= req.wdata[mpt_pkg::CTRL_TRIG_BIT];
            end
            mpt_pkg::ADDR_INTERVAL:
               interval_length_r <= req.wdata;
            default:
            begin
            end
         endcase
      end
   end

   // Zero-wait APB slave; unmapped addresses answer with pslverr.
   // Read data is captured in the setup cycle, so it shows the state one cycle
   // before the access edge. For the time counters that skew is far below a tick.
   // Writes to the read-only status and time registers are quietly ignored.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable)
         begin
            prdata <= 32'h0000_0000;
            unique case (req.addr)
               mpt_pkg::ADDR_CTRL:
                  prdata <= {25'h0, sw_trig_r, sw_clear_r, sw_hold_r, 1'b0, mode_r};
               mpt_pkg::ADDR_INTERVAL:
                  prdata <= interval_length_r;
               mpt_pkg::ADDR_STATUS:
                  prdata <= {30'h0, running_r, timer_out};
               mpt_pkg::ADDR_ELAPSED:
                  prdata <= elapsed_r;
               mpt_pkg::ADDR_REMAIN:
                  prdata <= sat_sub(interval_length_r, elapsed_r);
               default:
                  pslverr <= 1'b1;
            endcase
         end
      end
   end

   // A run finishes on the tick that brings the count up to the interval.
   assign done = running_r && tick && !hold_now && (elapsed_r + 32'h1 >= interval_length_r);

   // Previous value of the combined trigger, for edge and change detection.
   // Reset low, the idle level of the trigger, so no false edge follows reset.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         trig_prev <= 1'b0;
      else
         trig_prev <= trig_now;
   end

   // Timer core: one run counter and the output, updated per mode.
   // Clear is checked first and is level sensitive, so a trigger that arrives
   // together with it, or while it is held, never starts a run, except in change-delay mode once clear is released.
   // The shared increment below is overridden by the mode branches that restart.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         elapsed_r <= 32'h0000_0000;
         running_r <= 1'b0;
         timer_out <= 1'b0;
      end
      else if (clear_now)
      begin
         // Nothing else in the core is looked at while clear is active, which
         // is what makes clear dominant over every mode.
         elapsed_r <= 32'h0000_0000;
         running_r <= 1'b0;
         timer_out <= 1'b0;
      end
      else
      begin
         if (running_r && tick && !hold_now && !done)
            elapsed_r <= elapsed_r + 32'h1;
         unique case (mode_r)
            mpt_pkg::MODE_PULSE:
            begin
               if (done)
               begin
                  running_r <= 1'b0;
                  // The elapsed count is left at the interval so remaining reads
                  // zero until the next pulse starts.
                  timer_out <= 1'b0;
                  elapsed_r <= interval_length_r;
               end
               else if (trig_now && !trig_prev && !running_r)
               begin
                  // Edges during a running pulse fall through here and are ignored.
                  running_r <= 1'b1;
                  timer_out <= 1'b1;
                  elapsed_r <= 32'h0000_0000;
               end
            end
            mpt_pkg::MODE_ON_DELAY:
            begin
               if (!trig_now)
               begin
                  // A trigger that drops before the interval ends abandons the
                  // run, so short pulses never reach the output.
                  running_r <= 1'b0;
                  timer_out <= 1'b0;
                  elapsed_r <= 32'h0000_0000;
               end
               else if (!trig_prev)
               begin
                  running_r <= 1'b1;
                  elapsed_r <= 32'h0000_0000;
               end
               else if (done)
               begin
                  running_r <= 1'b0;
                  timer_out <= 1'b1;
                  elapsed_r <= interval_length_r;
               end
            end
            mpt_pkg::MODE_OFF_DELAY:
            begin
               if (trig_now)
               begin
                  running_r <= 1'b0;
                  timer_out <= 1'b1;
                  elapsed_r <= 32'h0000_0000;
               end
               else if (trig_prev)
               begin
                  // A falling trigger only starts the delay if the output is
                  // high; otherwise there is nothing to stretch.
                  running_r <= timer_out;
                  elapsed_r <= 32'h0000_0000;
               end
               else if (done)
               begin
                  running_r <= 1'b0;
                  timer_out <= 1'b0;
                  elapsed_r <= interval_length_r;
               end
            end
            mpt_pkg::MODE_CHANGE:
            begin
               if (trig_now == timer_out)
               begin
                  running_r <= 1'b0;
                  elapsed_r <= 32'h0000_0000;
               end
               else if (trig_now != trig_prev || !running_r)
               begin
                  // Any change of the input restarts the stability count.
                  running_r <= 1'b1;
                  elapsed_r <= 32'h0000_0000;
               end
               else if (done)
               begin
                  running_r <= 1'b0;
                  // The input has held its new value for the whole interval.
                  // The count is zeroed because the next change starts a new run.
                  timer_out <= trig_now;
                  elapsed_r <= 32'h0000_0000;
               end
            end
            default:
            begin
               running_r <= 1'b0;
            end
         endcase
      end
   end

   // Time outputs in ticks, registered.
   // They lag the internal count by one cycle so that every output of the block
   // comes straight from a flip-flop.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         elapsed_time <= 32'h0000_0000;
         remaining_time <= 32'h0000_0000;
      end
      else
      begin
         elapsed_time <= elapsed_r;
         remaining_time <= sat_sub(interval_length_r, elapsed_r);
      end
   end
endmodule : mpt_timer
`default_nettype wire

// ### shared/mpt_pkg.sv
// Shared constants and types for the multipurpose pulse timer.
`default_nettype none
package mpt_pkg;
   // Clock and sampling.
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
   localparam int unsigned TICKS_PER_S = 1000000 / TICK_US;
   localparam int unsigned CNT_W = 32;
   localparam int unsigned DIV_W = 16;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
   // Interval default: 1.0 s, in milliseconds and then in ticks.
   localparam int unsigned INTERVAL_DEF_MS = 1000;
   localparam logic [CNT_W-1:0] INTERVAL_DEF_TICKS = CNT_W'(INTERVAL_DEF_MS * TICKS_PER_S / 1000);
   // APB register map.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_INTERVAL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_ELAPSED = 8'h0C;
   localparam logic [7:0] ADDR_REMAIN = 8'h10;
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_HOLD_BIT = 4;
   localparam int unsigned CTRL_CLEAR_BIT = 5;
   localparam int unsigned CTRL_TRIG_BIT = 6;
   localparam int unsigned STAT_OUT_BIT = 0;
   localparam int unsigned STAT_RUN_BIT = 1;
   localparam logic [2:0] MODE_PULSE = 3'h1;
   localparam logic [2:0] MODE_ON_DELAY = 3'h2;
   localparam logic [2:0] MODE_OFF_DELAY = 3'h3;
   localparam logic [2:0] MODE_CHANGE = 3'h4;
   localparam logic [2:0] MODE_RESET = MODE_PULSE;

   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic [31:0] wdata;
   } mpt_req_s;
endpackage : mpt_pkg
`default_nettype wire

// ### tb/mpt_ctl_model.sv
// Model of the control logic that drives trigger, hold and clear.
`default_nettype none
module mpt_ctl_model
(
   input wire logic pclk,
   output logic trigger_in,
   output logic hold_in,
   output logic priority_clear
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      trigger_in = 1'b0;
      hold_in = 1'b0;
      priority_clear = 1'b0;
   end
   // Pins move only just after a rising edge, so the synchronisers never see a race.
   task automatic drive(input logic t, input logic h, input logic c);
      @(posedge pclk);
      trigger_in <= t;
      hold_in <= h;
      priority_clear <= c;
   endtask : drive
endmodule : mpt_ctl_model
`default_nettype wire

// ### tb/mpt_timer_asserts.sv
// Port assertions for the multipurpose pulse timer.
`default_nettype none
module mpt_timer_asserts
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic trigger_in,
   input wire logic hold_in,
   input wire logic priority_clear,
   input wire logic timer_out,
   input wire logic [31:0] elapsed_time
);
   logic [2:0] mode_r;
   logic [31:0] high_r;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Out-of-range mode writes are dropped, so the mirror keeps the old mode.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_r <= mpt_pkg::MODE_RESET;
         high_r <= 32'h0;
      end
      else
      begin
         high_r <= trigger_in ? high_r + 32'h1 : 32'h0;
         if (psel && penable && pready && pwrite && paddr == mpt_pkg::ADDR_CTRL
             && pwdata[2:0] inside {[3'h1:3'h4]})
            mode_r <= pwdata[2:0];
      end
   end
   a_ready_setup: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_err_map: assert property (pready |-> pslverr == (paddr > mpt_pkg::ADDR_REMAIN || paddr[1:0] != 2'h0))
      else $error("pslverr wrong");
   a_clear_wins: assert property (priority_clear [*4] |=> !timer_out && elapsed_time == 32'h0)
      else $error("clear not obeyed");
   a_hold_freeze: assert property ((hold_in && !priority_clear && $stable(trigger_in)) [*6] |=> $stable(elapsed_time))
      else $error("elapsed moved in hold");
   a_tick_step: assert property ($changed(elapsed_time) |-> elapsed_time == $past(elapsed_time) + 32'h1 || elapsed_time == 32'h0)
      else $error("elapsed step wrong");
   a_pulse_start: assert property (mode_r == mpt_pkg::MODE_PULSE && $rose(trigger_in) && !timer_out && !hold_in && !priority_clear |-> ##[1:4] timer_out)
      else $error("pulse did not start");
   a_pulse_len: assert property ($rose(timer_out) && mode_r == mpt_pkg::MODE_PULSE |=> timer_out [*8])
      else $error("pulse too short");
   a_on_filter: assert property (mode_r == mpt_pkg::MODE_ON_DELAY && $rose(timer_out) |-> high_r >= 32'h4E1F)
      else $error("on delay too early");
endmodule : mpt_timer_asserts
bind mpt_timer mpt_timer_asserts u_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
   .pslverr, .trigger_in, .hold_in, .priority_clear, .timer_out, .elapsed_time);
`default_nettype wire

// ### tb/tb_multipurpose_pulse_timer.sv
// Self-checking testbench for the multipurpose pulse timer.
`default_nettype none
module tb_multipurpose_pulse_timer;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, elapsed_time, remaining_time, rd;
   logic pready, pslverr, trigger_in, hold_in, priority_clear, timer_out, er;
   int mismatches = 0, checked = 0;
   always #25 pclk = ~pclk;
   mpt_timer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .trigger_in, .hold_in, .priority_clear, .timer_out, .elapsed_time, .remaining_time);
   mpt_ctl_model u_ctl (.pclk, .trigger_in, .hold_in, .priority_clear);
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   task automatic cyc(input int n);
      repeat (n) @(negedge pclk);
   endtask : cyc
   // A tick is 20000 cycles, so each wait gets one tick plus margin.
   task automatic wait_et(input logic [31:0] v);
      int n;
      n = 0;
      while (elapsed_time !== v && n < 20100)
      begin
         @(negedge pclk);
         n++;
      end
      chk("elapsed", elapsed_time, v);
   endtask : wait_et
   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      repeat (105000) @(posedge pclk);
      mismatches++;
      tally_and_finish();
   end
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      cyc(2);
      chk("remaining", remaining_time, mpt_pkg::INTERVAL_DEF_TICKS);
      xfer(mpt_pkg::ADDR_CTRL, 1'b0, 32'h0);
      chk("ctrl", rd, 32'(mpt_pkg::MODE_RESET));
      xfer(8'h14, 1'b0, 32'h0);
      chk("slverr", 32'(er), 32'h1);
      xfer(mpt_pkg::ADDR_INTERVAL, 1'b1, 32'h2);
      xfer(mpt_pkg::ADDR_INTERVAL, 1'b0, 32'h0);
      chk("interval", rd, 32'h2);
      for (int m = 5; m > 0; m--)
      begin
         xfer(mpt_pkg::ADDR_CTRL, 1'b1, 32'(m));
         xfer(mpt_pkg::ADDR_CTRL, 1'b0, 32'h0);
         chk("mode", rd, m == 5 ? 32'h1 : 32'(m));
      end
      u_ctl.drive(1'b1, 1'b0, 1'b0);
      cyc(6);
      chk("out", 32'(timer_out), 32'h1);
      wait_et(32'h1);
      u_ctl.drive(1'b0, 1'b0, 1'b0);
      cyc(4);
      u_ctl.drive(1'b1, 1'b0, 1'b0);
      cyc(6);
      chk("retrigger", elapsed_time, 32'h1);
      chk("out", 32'(timer_out), 32'h1);
      wait_et(32'h2);
      cyc(2);
      chk("out", 32'(timer_out), 32'h0);
      chk("remaining", remaining_time, 32'h0);
      u_ctl.drive(1'b0, 1'b0, 1'b0);
      xfer(mpt_pkg::ADDR_CTRL, 1'b1, 32'(mpt_pkg::MODE_ON_DELAY));
      u_ctl.drive(1'b1, 1'b0, 1'b0);
      wait_et(32'h1);
      u_ctl.drive(1'b1, 1'b1, 1'b0);
      cyc(20200);
      chk("hold", elapsed_time, 32'h1);
      chk("out", 32'(timer_out), 32'h0);
      u_ctl.drive(1'b1, 1'b0, 1'b0);
      wait_et(32'h2);
      cyc(2);
      chk("out", 32'(timer_out), 32'h1);
      u_ctl.drive(1'b1, 1'b0, 1'b1);
      cyc(6);
      chk("out", 32'(timer_out), 32'h0);
      chk("elapsed", elapsed_time, 32'h0);
      u_ctl.drive(1'b0, 1'b0, 1'b0);
      xfer(mpt_pkg::ADDR_CTRL, 1'b1, 32'(mpt_pkg::MODE_OFF_DELAY));
      u_ctl.drive(1'b1, 1'b0, 1'b0);
      cyc(6);
      chk("out", 32'(timer_out), 32'h1);
      u_ctl.drive(1'b0, 1'b0, 1'b0);
      cyc(4);
      u_ctl.drive(1'b1, 1'b0, 1'b0);
      cyc(6);
      chk("out", 32'(timer_out), 32'h1);
      chk("elapsed", elapsed_time, 32'h0);
      u_ctl.drive(1'b0, 1'b0, 1'b0);
      cyc(6);
      chk("out", 32'(timer_out), 32'h1);
      xfer(mpt_pkg::ADDR_STATUS, 1'b0, 32'h0);
      chk("status", rd, 32'h3);
      xfer(mpt_pkg::ADDR_ELAPSED, 1'b0, 32'h0);
      chk("elapsed_reg", rd, 32'h0);
      xfer(mpt_pkg::ADDR_REMAIN, 1'b0, 32'h0);
      chk("remain_reg", rd, 32'h2);
      u_ctl.drive(1'b0, 1'b0, 1'b1);
      cyc(6);
      chk("out", 32'(timer_out), 32'h0);
      u_ctl.drive(1'b0, 1'b0, 1'b0);
      xfer(mpt_pkg::ADDR_CTRL, 1'b1, 32'(mpt_pkg::MODE_CHANGE));
      u_ctl.drive(1'b1, 1'b0, 1'b0);
      cyc(6);
      chk("out", 32'(timer_out), 32'h0);
      xfer(mpt_pkg::ADDR_STATUS, 1'b0, 32'h0);
      chk("status", rd, 32'h2);
      chk("slverr", 32'(er), 32'h0);
      tally_and_finish();
   end
endmodule : tb_multipurpose_pulse_timer
`default_nettype wire
